// ===== pkg/spsd_params.svh
// Constants of the SPI page selection and code decryption front end
// Function
// - Code words coming over SPI for Code RAM are decrypted on the fly and only the plain result is stored.
// - The decryption of Code RAM writes is always on and has no bypass.
// - Each write to the page selection register that selects code memory restarts the cipher.
// - The page selection register answers at its fixed address whatever page is selected.
// - With page value 000 every access except to the page selection register is ignored.
// - Page value 001 routes accesses to Code RAM one and 010 to Code RAM two.
// - Page value 011 sends each write to both Code RAMs and reads are not served there.
// - A written value with the top bit set is stored as 100 and selects the common page.
// - The common page reaches every area except the Code RAMs.
// - The internal address and the page value are decoded into one select per addressed area.
// - Each channel has three selects: 0 Data RAM, 1 Code RAM, 2 configuration registers.
// - Separate selects exist for main configuration, I/O configuration and diagnosis registers.
`ifndef SPSD_PARAMS_SVH
`define SPSD_PARAMS_SVH

// ==========================================================
// Widths
`define SPSD_ADDR_W       10
`define SPSD_DATA_W       16
`define SPSD_PAGE_W       3
`define SPSD_FIFO_DEPTH   16

// ==========================================================
// Page selection register
`define SPSD_PAGE_ADDR    10'h3FF
`define SPSD_PAGE_RESET   3'h0
`define SPSD_PAGE_NONE    3'h0
`define SPSD_PAGE_CODE1   3'h1
`define SPSD_PAGE_CODE2   3'h2
`define SPSD_PAGE_DUAL    3'h3
`define SPSD_PAGE_COMMON  3'h4
`define SPSD_PAGE_TOP_BIT 2

// ==========================================================
// Select indexes inside a channel group
`define SPSD_SEL_DRAM     0
`define SPSD_SEL_CRAM     1
`define SPSD_SEL_CFG      2

// ==========================================================
// Common page areas, first and last word address
`define SPSD_DRAM1_FIRST  10'h000
`define SPSD_DRAM1_LAST   10'h07F
`define SPSD_DRAM2_FIRST  10'h080
`define SPSD_DRAM2_LAST   10'h0FF
`define SPSD_CFG1_FIRST   10'h100
`define SPSD_CFG1_LAST    10'h13F
`define SPSD_CFG2_FIRST   10'h140
`define SPSD_CFG2_LAST    10'h17F
`define SPSD_IO_FIRST     10'h180
`define SPSD_IO_LAST      10'h1BF
`define SPSD_MCR_FIRST    10'h1C0
`define SPSD_MCR_LAST     10'h1FF
`define SPSD_DIAG_FIRST   10'h200
`define SPSD_DIAG_LAST    10'h23F

// ==========================================================
// Cipher keystream (seed value arbitrary)
`define SPSD_CIPHER_SEED  16'hACE1
`define SPSD_CIPHER_TAPS  16'hB400

`endif

// ===== pkg/spsd_pkg.sv
// Types shared by the page selection front end
`default_nettype none
`include "spsd_params.svh"

package spsd_pkg;

	typedef logic [`SPSD_ADDR_W-1:0] spsd_addr_t;
	typedef logic [`SPSD_DATA_W-1:0] spsd_word_t;
	typedef logic [`SPSD_PAGE_W-1:0] spsd_page_t;

	// Area hit by a common page address
	typedef enum logic [2:0] {
		SPSD_AREA_NONE,
		SPSD_AREA_DRAM1,
		SPSD_AREA_DRAM2,
		SPSD_AREA_CFG1,
		SPSD_AREA_CFG2,
		SPSD_AREA_MCR,
		SPSD_AREA_IO,
		SPSD_AREA_DIAG
	} spsd_area_t;

endpackage

`default_nettype wire

// ===== hdl/spsd_fifo.sv
// Request FIFO between the SPI side and the decoder
`timescale 1ns/1ps
`default_nettype none

module spsd_fifo #(
	parameter int WIDTH = 27,
	parameter int DEPTH = 16
) (
	input  wire logic             i_clock,     // System clock
	input  wire logic             i_reset,     // Async reset, high
	input  wire logic             i_in_valid,  // Write side valid
	output logic                  o_in_ready,  // Write side ready
	input  wire logic [WIDTH-1:0] i_in_data,   // Write side word
	output logic                  o_out_valid, // Read side valid
	input  wire logic             i_out_ready, // Read side ready
	output logic [WIDTH-1:0]      o_out_data   // Read side word
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];
	logic [AW-1:0]    wr_index;
	logic [AW-1:0]    rd_index;
	logic [AW:0]      count;
	wire              push;
	wire              pop;

	// Handshake terms
	assign o_in_ready  = (count != (AW+1)'(DEPTH));
	assign o_out_valid = (count != '0);
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;
	assign o_out_data  = store[rd_index];

	// Storage
	always_ff @(posedge i_clock) begin
		if (push) begin
			store[wr_index] <= i_in_data;
		end
	end

	// Pointers and fill count
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			wr_index <= '0;
			rd_index <= '0;
			count    <= '0;
		end else begin
			if (push) begin
				wr_index <= (wr_index == AW'(DEPTH-1)) ? '0 : wr_index + 1'b1;
			end
			if (pop) begin
				rd_index <= (rd_index == AW'(DEPTH-1)) ? '0 : rd_index + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

endmodule

`default_nettype wire

// ===== hdl/spsd_top.sv
// Page selection, area decoding and code decryption for SPI accesses
`timescale 1ns/1ps
`default_nettype none
`include "spsd_params.svh"

module spsd_top
	import spsd_pkg::*;
(
	input  wire logic       i_clock,                    // System clock, 25 MHz
	input  wire logic       i_reset,                    // Async reset, high
	input  wire logic       i_req_valid,                // SPI access offered
	output logic            o_req_ready,                // FIFO can take it
	input  wire logic       i_req_write,                // 1 write, 0 read
	input  wire spsd_addr_t i_req_addr,                 // Word address
	input  wire spsd_word_t i_req_wdata,                // Write data
	input  wire logic       i_bus_ready,                // Areas accept an access
	output spsd_addr_t      o_bus_addr,                 // Address to areas
	output spsd_word_t      o_bus_wdata,                // Data to areas
	output logic            o_bus_write,                // Write strobe
	output logic            o_bus_read,                 // Read strobe
	output logic [2:0]      o_channel_one_area_selects, // Channel one selects
	output logic [2:0]      o_channel_two_area_selects, // Channel two selects
	output logic            o_main_config_select,       // Main configuration
	output logic            o_io_config_select,         // I/O configuration
	output logic            o_diag_config_select,       // Diagnosis configuration
	input  wire spsd_word_t i_area_rdata,               // Area read data
	output logic            o_resp_valid,               // Read answer pulse
	output spsd_word_t      o_resp_data,                // Read answer data
	output logic            o_access_ignored,           // Access dropped pulse
	output spsd_page_t      o_page_selection            // Current page value
);

	localparam int REQ_W = 1 + `SPSD_ADDR_W + `SPSD_DATA_W;

	// ==========================================================
	// Functions

	// Stored form of a written page value
	function automatic spsd_page_t coerce_page(input spsd_page_t value);
		coerce_page = value[`SPSD_PAGE_TOP_BIT] ? `SPSD_PAGE_COMMON : value;
	endfunction

	// True when a page value points at code memory
	function automatic logic is_code_page(input spsd_page_t value);
		is_code_page = (value == `SPSD_PAGE_CODE1) || (value == `SPSD_PAGE_CODE2) ||
			(value == `SPSD_PAGE_DUAL);
	endfunction

	// Common page area lookup
	function automatic spsd_area_t decode_area(input spsd_addr_t a);
		if (a >= `SPSD_DRAM1_FIRST && a <= `SPSD_DRAM1_LAST) begin
			decode_area = SPSD_AREA_DRAM1;
		end else if (a >= `SPSD_DRAM2_FIRST && a <= `SPSD_DRAM2_LAST) begin
			decode_area = SPSD_AREA_DRAM2;
		end else if (a >= `SPSD_CFG1_FIRST && a <= `SPSD_CFG1_LAST) begin
			decode_area = SPSD_AREA_CFG1;
		end else if (a >= `SPSD_CFG2_FIRST && a <= `SPSD_CFG2_LAST) begin
			decode_area = SPSD_AREA_CFG2;
		end else if (a >= `SPSD_IO_FIRST && a <= `SPSD_IO_LAST) begin
			decode_area = SPSD_AREA_IO;
		end else if (a >= `SPSD_MCR_FIRST && a <= `SPSD_MCR_LAST) begin
			decode_area = SPSD_AREA_MCR;
		end else if (a >= `SPSD_DIAG_FIRST && a <= `SPSD_DIAG_LAST) begin
			decode_area = SPSD_AREA_DIAG;
		end else begin
			decode_area = SPSD_AREA_NONE;
		end
	endfunction

	// One keystream step, Galois form
	function automatic spsd_word_t lfsr_next(input spsd_word_t s);
		lfsr_next = s[0] ? ((s >> 1) ^ `SPSD_CIPHER_TAPS) : (s >> 1);
	endfunction

	// ==========================================================
	// Request FIFO

	logic [REQ_W-1:0] fifo_out;
	logic             fifo_valid;
	wire              issue;

	spsd_fifo #(
		.WIDTH (REQ_W),
		.DEPTH (`SPSD_FIFO_DEPTH)
	) u_fifo (
		.i_clock     (i_clock),
		.i_reset     (i_reset),
		.i_in_valid  (i_req_valid),
		.o_in_ready  (o_req_ready),
		.i_in_data   ({i_req_write, i_req_addr, i_req_wdata}),
		.o_out_valid (fifo_valid),
		.i_out_ready (i_bus_ready),
		.o_out_data  (fifo_out)
	);

	// ==========================================================
	// Decoding

	spsd_page_t page;
	spsd_word_t keystream;
	logic       rd_pending;
	logic       rd_from_page;
	spsd_word_t rd_page_word;

	wire        cur_write;
	spsd_addr_t cur_addr;
	spsd_word_t cur_wdata;
	wire        page_hit;
	wire        page_write;
	spsd_page_t page_new;
	spsd_area_t area;
	wire        code_access;
	wire        code_write;
	logic [2:0] next_sel_one;
	logic [2:0] next_sel_two;
	wire        next_mcr;
	wire        next_io;
	wire        next_diag;
	wire        any_sel;
	spsd_word_t next_wdata;

	// Unpack the FIFO head and classify it
	assign {cur_write, cur_addr, cur_wdata} = fifo_out;
	assign issue       = fifo_valid && i_bus_ready;
	assign page_hit    = (cur_addr == `SPSD_PAGE_ADDR);
	assign page_write  = issue && page_hit && cur_write;
	assign page_new    = coerce_page(cur_wdata[`SPSD_PAGE_W-1:0]);
	assign area        = (page == `SPSD_PAGE_COMMON) ? decode_area(cur_addr) : SPSD_AREA_NONE;

	// Code RAM pages, dual page only for writes
	assign code_access = !page_hit && (page == `SPSD_PAGE_CODE1 || page == `SPSD_PAGE_CODE2 ||
		(page == `SPSD_PAGE_DUAL && cur_write));
	assign code_write  = issue && code_access && cur_write;

	// Per area selects, none under page zero
	always_comb begin
		next_sel_one = 3'h0;
		next_sel_two = 3'h0;
		if (issue && !page_hit) begin
			next_sel_one[`SPSD_SEL_CRAM] = code_access && page[0];
			next_sel_two[`SPSD_SEL_CRAM] = code_access && page[1];
			next_sel_one[`SPSD_SEL_DRAM] = (area == SPSD_AREA_DRAM1);
			next_sel_two[`SPSD_SEL_DRAM] = (area == SPSD_AREA_DRAM2);
			next_sel_one[`SPSD_SEL_CFG]  = (area == SPSD_AREA_CFG1);
			next_sel_two[`SPSD_SEL_CFG]  = (area == SPSD_AREA_CFG2);
		end
	end

	// Shared register areas
	assign next_mcr  = issue && !page_hit && (area == SPSD_AREA_MCR);
	assign next_io   = issue && !page_hit && (area == SPSD_AREA_IO);
	assign next_diag = issue && !page_hit && (area == SPSD_AREA_DIAG);
	assign any_sel   = (next_sel_one != 3'h0) || (next_sel_two != 3'h0) ||
		next_mcr || next_io || next_diag;

	// Code writes always pass the cipher
	assign next_wdata = code_write ? (cur_wdata ^ keystream) : cur_wdata;

	// ==========================================================
	// Page selection register
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			page <= `SPSD_PAGE_RESET;
		end else if (page_write) begin
			page <= page_new;
		end
	end

	assign o_page_selection = page;

	// ==========================================================
	// Keystream, restarted by a code page selection
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			keystream <= `SPSD_CIPHER_SEED;
		end else if (page_write && is_code_page(page_new)) begin
			keystream <= `SPSD_CIPHER_SEED;
		end else if (code_write) begin
			keystream <= lfsr_next(keystream);
		end
	end

	// ==========================================================
	// Area strobes, one cycle per access
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			o_channel_one_area_selects <= 3'h0;
			o_channel_two_area_selects <= 3'h0;
			o_main_config_select       <= 1'b0;
			o_io_config_select         <= 1'b0;
			o_diag_config_select       <= 1'b0;
			o_bus_write                <= 1'b0;
			o_bus_read                 <= 1'b0;
		end else begin
			o_channel_one_area_selects <= next_sel_one;
			o_channel_two_area_selects <= next_sel_two;
			o_main_config_select       <= next_mcr;
			o_io_config_select         <= next_io;
			o_diag_config_select       <= next_diag;
			o_bus_write                <= any_sel && cur_write;
			o_bus_read                 <= any_sel && !cur_write;
		end
	end

	// Address and data follow the strobes
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			o_bus_addr  <= '0;
			o_bus_wdata <= '0;
		end else if (issue) begin
			o_bus_addr  <= cur_addr;
			o_bus_wdata <= next_wdata;
		end
	end

	// ==========================================================
	// Read answer, two cycles after the issue
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			rd_pending   <= 1'b0;
			rd_from_page <= 1'b0;
			rd_page_word <= '0;
		end else begin
			rd_pending   <= issue && !cur_write;
			rd_from_page <= page_hit;
			rd_page_word <= {{(`SPSD_DATA_W-`SPSD_PAGE_W){1'b0}}, page};
		end
	end

	// Answer data, zero for a dropped read
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			o_resp_valid     <= 1'b0;
			o_resp_data      <= '0;
			o_access_ignored <= 1'b0;
		end else begin
			o_resp_valid     <= rd_pending;
			o_access_ignored <= issue && !page_hit && !any_sel;
			if (rd_pending) begin
				o_resp_data <= rd_from_page ? rd_page_word :
					(o_bus_read ? i_area_rdata : '0);
			end
		end
	end

	// ==========================================================
	// Checks
	wire [8:0] sel_all = {o_channel_one_area_selects, o_channel_two_area_selects,
		o_main_config_select, o_io_config_select, o_diag_config_select};

	sequence s_read_issue;
		issue && !cur_write;
	endsequence

	sequence s_read_answer;
		##2 o_resp_valid;
	endsequence

	a_page_top_coerce: assert property (
		@(posedge i_clock) disable iff (i_reset)
		page[`SPSD_PAGE_TOP_BIT] |-> (page[1:0] == 2'h0))
		else $error("page value with top bit not coerced");

	a_page_write_store: assert property (
		@(posedge i_clock) disable iff (i_reset)
		page_write |=> (page == coerce_page($past(cur_wdata[`SPSD_PAGE_W-1:0]))))
		else $error("page write not stored");

	a_none_page_quiet: assert property (
		@(posedge i_clock) disable iff (i_reset)
		(issue && page == `SPSD_PAGE_NONE && !page_hit) |=> (sel_all == 9'h000) && o_access_ignored)
		else $error("access served with no page selected");

	a_one_select_max: assert property (
		@(posedge i_clock) disable iff (i_reset)
		!(o_bus_write && $past(page) == `SPSD_PAGE_DUAL) |-> $onehot0(sel_all))
		else $error("more than one area select");

	a_dual_write_both: assert property (
		@(posedge i_clock) disable iff (i_reset)
		(issue && cur_write && !page_hit && page == `SPSD_PAGE_DUAL)
		|=> o_channel_one_area_selects[`SPSD_SEL_CRAM] && o_channel_two_area_selects[`SPSD_SEL_CRAM])
		else $error("dual write missed a code memory");

	a_dual_read_drop: assert property (
		@(posedge i_clock) disable iff (i_reset)
		(issue && !cur_write && !page_hit && page == `SPSD_PAGE_DUAL) |=> !o_bus_read)
		else $error("read served under dual selection");

	a_code_decrypt_data: assert property (
		@(posedge i_clock) disable iff (i_reset)
		code_write |=> (o_bus_wdata == ($past(cur_wdata) ^ $past(keystream))))
		else $error("code word not decrypted");

	a_cipher_restart_seed: assert property (
		@(posedge i_clock) disable iff (i_reset)
		(page_write && is_code_page(page_new)) |=> (keystream == `SPSD_CIPHER_SEED))
		else $error("cipher not restarted");

	a_common_no_code: assert property (
		@(posedge i_clock) disable iff (i_reset)
		(issue && page == `SPSD_PAGE_COMMON)
		|=> !o_channel_one_area_selects[`SPSD_SEL_CRAM] && !o_channel_two_area_selects[`SPSD_SEL_CRAM])
		else $error("code memory reached from common page");

	a_read_answer_time: assert property (
		@(posedge i_clock) disable iff (i_reset)
		s_read_issue |-> s_read_answer)
		else $error("read answer late");

	a_ignored_no_strobe: assert property (
		@(posedge i_clock) disable iff (i_reset)
		o_access_ignored |-> (sel_all == 9'h000) && !o_bus_write && !o_bus_read)
		else $error("ignored access raised a strobe");

	a_code_one_route: assert property (
		@(posedge i_clock) disable iff (i_reset)
		(issue && !page_hit && page == `SPSD_PAGE_CODE1)
		|=> (o_channel_one_area_selects == 3'h2) && (o_channel_two_area_selects == 3'h0))
		else $error("code page one misrouted");

	a_code_two_route: assert property (
		@(posedge i_clock) disable iff (i_reset)
		(issue && !page_hit && page == `SPSD_PAGE_CODE2)
		|=> (o_channel_two_area_selects == 3'h2) && (o_channel_one_area_selects == 3'h0))
		else $error("code page two misrouted");

	a_cipher_step_next: assert property (
		@(posedge i_clock) disable iff (i_reset)
		code_write |=> (keystream == lfsr_next($past(keystream))))
		else $error("keystream did not advance");

	a_strobe_has_select: assert property (
		@(posedge i_clock) disable iff (i_reset)
		(o_bus_write || o_bus_read) |-> (sel_all != 9'h000))
		else $error("strobe with no area select");

	a_data_ram_one: assert property (
		@(posedge i_clock) disable iff (i_reset)
		(issue && area == SPSD_AREA_DRAM1) |=> (o_channel_one_area_selects == 3'h1))
		else $error("data memory one not selected");

	a_main_cfg_select: assert property (
		@(posedge i_clock) disable iff (i_reset)
		(issue && area == SPSD_AREA_MCR) |=> o_main_config_select && !o_io_config_select)
		else $error("main configuration not selected");

endmodule

`default_nettype wire

// ===== verif/spsd_area_model.sv
// Far side model: memory and register areas answering the decoder
`timescale 1ns/1ps
`default_nettype none

module spsd_area_model (
	input  wire logic       i_clock, // System clock
	input  wire logic       i_reset, // Async reset, high
	input  wire logic [1:0] i_mode,  // 0 prompt, 1 slow, 2 stopped
	input  wire logic [9:0] i_addr,  // Decoder address
	input  wire logic [8:0] i_sels,  // All area selects
	output logic            o_ready, // Areas accept
	output logic [15:0]     o_rdata  // Area read data
);
	logic        tick;
	logic [15:0] last;

	// ==========================================================
	// Ready pattern; idle data is the inverse of the last value
	assign o_ready = (i_mode == 2'h0) || (i_mode == 2'h1 && tick);
	assign o_rdata = (|i_sels) ? (16'hA000 ^ {6'h00, i_addr}) : ~last;

	// Stall phase and last driven data
	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			tick <= 1'b0;
			last <= 16'h0000;
		end else begin
			tick <= ~tick;
			last <= o_rdata;
		end
	end
endmodule
`default_nettype wire

// ===== verif/tb.sv
// Testbench of the page selection and decryption front end
`timescale 1ns/1ps
`default_nettype none
`include "spsd_params.svh"

module tb;
	logic        clock, reset, req_valid, req_ready, req_write, bus_ready;
	logic        bus_write, bus_read, resp_valid, ignored, mcr, io, diag;
	logic [9:0]  req_addr, bus_addr;
	logic [15:0] req_wdata, bus_wdata, area_rdata, resp_data, ks;
	logic [2:0]  sel1, sel2, page;
	logic [1:0]  mode;
	int          n_errors, checks, n_ign, cycles;
	logic [19:0] evq[$];
	logic [15:0] wdq[$], rsq[$];

	// ==========================================================
	// Design, far side model and clock
	spsd_top DUT (.i_clock(clock), .i_reset(reset), .i_req_valid(req_valid),
		.o_req_ready(req_ready), .i_req_write(req_write), .i_req_addr(req_addr),
		.i_req_wdata(req_wdata), .i_bus_ready(bus_ready), .o_bus_addr(bus_addr),
		.o_bus_wdata(bus_wdata), .o_bus_write(bus_write), .o_bus_read(bus_read),
		.o_channel_one_area_selects(sel1), .o_channel_two_area_selects(sel2),
		.o_main_config_select(mcr), .o_io_config_select(io),
		.o_diag_config_select(diag), .i_area_rdata(area_rdata),
		.o_resp_valid(resp_valid), .o_resp_data(resp_data),
		.o_access_ignored(ignored), .o_page_selection(page));
	spsd_area_model u_area (.i_clock(clock), .i_reset(reset), .i_mode(mode),
		.i_addr(bus_addr), .i_sels({sel1, sel2, mcr, io, diag}),
		.o_ready(bus_ready), .o_rdata(area_rdata));
	always #20 clock = ~clock;

	// ==========================================================
	// Monitor of area events, answers and dropped accesses
	always @(posedge clock) begin
		if (!reset && (|{sel1, sel2, mcr, io, diag})) begin
			evq.push_back({sel1, sel2, mcr, io, diag, bus_write, bus_addr});
			wdq.push_back(bus_wdata);
			chk("read_strobe", bus_read, !bus_write);
		end
		if (!reset && resp_valid)
			rsq.push_back(resp_data);
		if (!reset && ignored)
			n_ign++;
	end

	// Hang guard
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			end_sim();
		end
	end

	// ==========================================================
	// Shared tasks
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// One access, held until taken
	task automatic acc(input logic w, input logic [9:0] a, input logic [15:0] d);
		@(negedge clock);
		req_valid = 1'b1;
		req_write = w;
		req_addr = a;
		req_wdata = d;
		while (!req_ready)
			@(negedge clock);
		@(posedge clock);
	endtask

	task automatic idle();
		@(negedge clock);
		req_valid = 1'b0;
		req_wdata = ~req_wdata;
	endtask

	// Page write; code pages restart the keystream
	task automatic pg(input logic [2:0] v);
		acc(1'b1, `SPSD_PAGE_ADDR, {13'h0000, v});
		if (v inside {3'h1, 3'h2, 3'h3})
			ks = `SPSD_CIPHER_SEED;
	endtask

	// Code word sent encrypted from the restart point
	task automatic cw(input logic [9:0] a, input logic [15:0] plain);
		acc(1'b1, a, plain ^ ks);
		ks = (ks >> 1) ^ (ks[0] ? `SPSD_CIPHER_TAPS : 16'h0000);
	endtask

	task automatic clr();
		evq.delete();
		wdq.delete();
		rsq.delete();
		n_ign = 0;
	endtask

	task automatic settle(input int ne, input int nr, input int ni);
		for (int k = 0; k < 300 && (evq.size() < ne || rsq.size() < nr || n_ign < ni); k++)
			@(posedge clock);
		@(negedge clock);
		chk("event_count", evq.size(), ne);
		chk("answer_count", rsq.size(), nr);
		chk("ignored_count", n_ign, ni);
	endtask

	task automatic ce(input int i, input logic [8:0] s, input logic w, input logic [9:0] a);
		chk("area_event", evq[i], {s, w, a});
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_none();
		clr();
		chk("page_reset", page, 3'h0);
		acc(1'b1, 10'h010, 16'h1234);
		acc(1'b0, 10'h100, 16'h0000);
		acc(1'b0, `SPSD_PAGE_ADDR, 16'h0000);
		idle();
		settle(0, 2, 2);
		chk("dropped_read", rsq[0], 16'h0000);
		chk("page_read_none", rsq[1], 16'h0000);
	endtask

	task automatic t_common();
		logic [9:0] ta [7] = '{10'h000, 10'h0FF, 10'h100, 10'h17F, 10'h180, 10'h1FF, 10'h23F};
		logic [8:0] ts [7] = '{9'h040, 9'h008, 9'h100, 9'h020, 9'h002, 9'h004, 9'h001};
		clr();
		for (int v = 5; v < 8; v++) begin
			pg(v[2:0]);
			acc(1'b0, `SPSD_PAGE_ADDR, 16'h0000);
		end
		idle();
		settle(0, 3, 0);
		for (int v = 0; v < 3; v++)
			chk("page_top_bit", rsq[v], 16'h0004);
		chk("page_common", page, 3'h4);
		clr();
		@(negedge clock);
		mode = 2'h1;
		for (int i = 0; i < 7; i++)
			acc(1'b0, ta[i], 16'h0000);
		acc(1'b0, 10'h300, 16'h0000);
		idle();
		settle(7, 8, 1);
		for (int i = 0; i < 7; i++) begin
			ce(i, ts[i], 1'b0, ta[i]);
			chk("common_data", rsq[i], 16'hA000 ^ {6'h00, ta[i]});
		end
		chk("unmapped_data", rsq[7], 16'h0000);
	endtask

	task automatic t_code();
		clr();
		pg(3'h1);
		cw(10'h005, 16'h1111);
		cw(10'h006, 16'h2222);
		pg(3'h2);
		cw(10'h007, 16'h3333);
		acc(1'b0, 10'h008, 16'h0000);
		pg(3'h3);
		cw(10'h009, 16'h4444);
		acc(1'b0, 10'h00A, 16'h0000);
		idle();
		settle(5, 2, 1);
		ce(0, 9'h080, 1'b1, 10'h005);
		chk("code_word0", wdq[0], 16'h1111);
		chk("code_word1", wdq[1], 16'h2222);
		ce(2, 9'h010, 1'b1, 10'h007);
		chk("code_word2", wdq[2], 16'h3333);
		ce(3, 9'h010, 1'b0, 10'h008);
		chk("code_read", rsq[0], 16'hA008);
		ce(4, 9'h090, 1'b1, 10'h009);
		chk("dual_word", wdq[4], 16'h4444);
		chk("dual_read", rsq[1], 16'h0000);
	endtask

	task automatic t_fifo();
		clr();
		pg(3'h4);
		acc(1'b0, `SPSD_PAGE_ADDR, 16'h0000);
		idle();
		settle(0, 1, 0);
		chk("page_read_common", rsq[0], 16'h0004);
		mode = 2'h2;
		clr();
		for (int i = 0; i < 16; i++)
			acc(1'b1, i[9:0], i[15:0]);
		idle();
		chk("fifo_full", req_ready, 1'b0);
		mode = 2'h1;
		settle(16, 0, 0);
		chk("fifo_empty", req_ready, 1'b1);
		for (int i = 0; i < 16; i++) begin
			ce(i, 9'h040, 1'b1, i[9:0]);
			chk("fifo_data", wdq[i], i[15:0]);
		end
	endtask

	// Reset in mid-run clears the page and drops later accesses
	task automatic t_reset();
		clr();
		pg(3'h2);
		acc(1'b0, `SPSD_PAGE_ADDR, 16'h0000);
		idle();
		settle(0, 1, 0);
		chk("page_read_code", rsq[0], 16'h0002);
		@(negedge clock);
		reset = 1'b1;
		repeat (2) @(negedge clock);
		chk("page_in_reset", page, 3'h0);
		reset = 1'b0;
		clr();
		acc(1'b1, 10'h005, 16'h5555);
		idle();
		settle(0, 0, 1);
		chk("page_after_reset", page, 3'h0);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		clock = 1'b0;
		reset = 1'b1;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_addr = 10'h000;
		req_wdata = 16'h0000;
		mode = 2'h0;
		ks = `SPSD_CIPHER_SEED;
		n_errors = 0;
		checks = 0;
		cycles = 0;
		repeat (5) @(negedge clock);
		reset = 1'b0;
		t_none();
		t_common();
		t_code();
		t_fifo();
		t_reset();
		end_sim();
	end
endmodule
`default_nettype wire
